// ---- pkg/ast_consts.svh ----
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH
// register byte addresses
`define AST_OFF_RCSTA 8'h00
`define AST_OFF_TXBUF 8'h04
`define AST_OFF_TXSTA 8'h08
`define AST_OFF_BAUD 8'h0c
`define AST_OFF_DIVH 8'h10
`define AST_OFF_DIVL 8'h14
`define AST_OFF_RXBUF 8'h18
`define AST_OFF_INTEN 8'h1c
`define AST_OFF_FLAGS 8'h20
// receive_status_control fields
`define AST_RC_SERIAL_PORT_ENABLE 7
`define AST_RC_RX9 6
`define AST_RC_CONTINUOUS_RECEIVE_ENABLE 4
`define AST_RC_ADDRESS_DETECT_ENABLE 3
// transmit_status_control fields
`define AST_TX_TX9 6
`define AST_TX_TRANSMIT_ENABLE 5
`define AST_TX_SYNC 4
`define AST_TX_HIGH_SPEED_SELECT 2
`define AST_TX_TRANSMIT_NINTH_BIT 0
// baud_control fields
`define AST_BD_WIDE_GENERATOR_SELECT 3
`define AST_BD_WUE 1
// enable register fields
`define AST_EN_TXIE 1
`define AST_EN_RCIE 0
// oversampling phases
`define AST_PH_MID 4'h7
`define AST_PH_LAST 4'hf
`endif

// ---- pkg/ast_pkg.sv ----
package ast_pkg;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } ast_tx_state_t;
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_STOP = 5'b01000,
        RX_WLOW = 5'b10000
    } ast_rx_state_t;
endpackage : ast_pkg

// ---- sim/ast_remote_node.sv ----
module ast_remote_node (
    input wire logic clk_i,
    input wire logic [7:0] bit_clks_i,
    input wire logic nine_i,
    input wire logic line_i,
    output logic line_o,
    output logic [9:0] got_o,
    output logic got_valid_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] sh;
    initial
    begin
        line_o = 1'b1;
        got_valid_o = 1'b0;
    end
    // trailing idle bits (one in nine-bit, two in eight-bit) keep back-to-back frames from colliding
    task automatic send(input logic [8:0] d, input logic stop);
        logic [11:0] f;
        f = nine_i ? {1'b1, stop, d, 1'b0} : {2'b11, stop, d[7:0], 1'b0};
        for (int i = 0; i < 12; i++)
        begin
            line_o <= f[i];
            repeat (bit_clks_i) @(posedge clk_i);
        end
    endtask : send
    task automatic hold_low(input int n);
        line_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        line_o <= 1'b1;
    endtask : hold_low
    // samples mid-bit; got_o is {stop, ninth, data}
    always
    begin
        @(negedge line_i);
        repeat (bit_clks_i / 2) @(posedge clk_i);
        for (int i = 0; i < (nine_i ? 10 : 9); i++)
        begin
            repeat (bit_clks_i) @(posedge clk_i);
            sh = {line_i, sh[9:1]};
        end
        got_o <= nine_i ? sh : {sh[9], 1'b0, sh[8:1]};
        got_valid_o <= 1'b1;
        @(posedge clk_i);
        got_valid_o <= 1'b0;
    end
endmodule : ast_remote_node

// ---- sim/test_async_serial_transceiver.sv ----
`include "ast_consts.svh"
module test_async_serial_transceiver;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i;
    logic resetn_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, b, bit_clks = 8'h10;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, txd, rxd, tx_req, rx_req, got_v;
    logic nine = 1'b0;
    logic [9:0] got;
    logic [32:0] rd_q[$];
    logic [9:0] tx_q[$];
    logic [7:0] tx_m[3] = '{8'h20, 8'h20, 8'h24};
    logic [7:0] bd_m[3] = '{8'h00, 8'h08, 8'h00};
    logic [7:0] dl_m[3] = '{8'h00, 8'h01, 8'h00};
    logic [7:0] bc_m[3] = '{8'h40, 8'h20, 8'h10};
    int bad_count = 0;
    int total_checks = 0;
    integer seed = 32'ha88bc81c;

    ast_top ast_top_inst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .receive_line_i(rxd),
        .transmit_line_o(txd),
        .tx_request_o(tx_req),
        .rx_request_o(rx_req)
    );
    ast_remote_node ast_remote_node_inst (
        .clk_i(clk_i),
        .bit_clks_i(bit_clks),
        .nine_i(nine),
        .line_i(txd),
        .line_o(rxd),
        .got_o(got),
        .got_valid_o(got_v)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [32:0] g, input logic [32:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    // any frame with no note queued is a mismatch
    always @(posedge clk_i)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
            check({pslverr, prdata}, rd_q.pop_front());
        if (got_v === 1'b1)
            check({23'h0, got},
                tx_q.size() > 0 ? {23'h0, tx_q.pop_front()} : '1);
    end

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do
            @(posedge clk_i);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic snd(input logic [8:0] d, input logic s);
        ast_remote_node_inst.send(d, s);
    endtask : snd

    task automatic wait_rx;
        int n = 0;
        while (rx_req !== 1'b1 && n++ < 4000)
            @(posedge clk_i);
        if (rx_req !== 1'b1)
            bad_count++;
    endtask : wait_rx

    // extra cycles let the stop bit finish after the node's mid sample
    task automatic wait_tx;
        int n = 0;
        while (tx_q.size() > 0 && n++ < 4000)
            @(posedge clk_i);
        if (tx_q.size() > 0)
            bad_count++;
        repeat (40) @(posedge clk_i);
    endtask : wait_tx

    initial
    begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        rd(`AST_OFF_TXSTA, 33'h02);
        rd(`AST_OFF_FLAGS, 33'h00);
        rd(8'h24, 33'h1_0000_0000);
        $display("reset values done");
        wr(`AST_OFF_INTEN, 8'h03);
        rd(`AST_OFF_INTEN, 33'h03);
        b = 8'($random(seed));
        wr(`AST_OFF_DIVH, b);
        rd(`AST_OFF_DIVH, {25'h0, b});
        wr(`AST_OFF_DIVH, 8'h00);
        wr(`AST_OFF_RCSTA, 8'h90);
        wr(`AST_OFF_TXSTA, 8'h24);
        rd(`AST_OFF_FLAGS, 33'h02);
        wr(`AST_OFF_FLAGS, 8'h00);
        rd(`AST_OFF_FLAGS, 33'h02);
        check({32'h0, tx_req}, 33'h1);
        $display("enable done");
        for (int m = 0; m < 3; m++)
        begin
            wr(`AST_OFF_TXSTA, tx_m[m]);
            wr(`AST_OFF_BAUD, bd_m[m]);
            wr(`AST_OFF_DIVL, dl_m[m]);
            bit_clks = bc_m[m];
            b = 8'($random(seed));
            tx_q.push_back({2'b10, b});
            fork
                snd({1'b0, ~b}, 1'b1);
                wr(`AST_OFF_TXBUF, b);
            join
            wait_rx;
            rd(`AST_OFF_RXBUF, {25'h0, ~b});
            wait_tx;
        end
        $display("rates done");
        tx_q.push_back({2'b10, b});
        tx_q.push_back({2'b10, ~b});
        wr(`AST_OFF_TXBUF, b);
        wr(`AST_OFF_TXBUF, ~b);
        repeat (2) @(posedge clk_i);
        rd(`AST_OFF_FLAGS, 33'h00);
        rd(`AST_OFF_TXSTA, 33'h24);
        wait_tx;
        rd(`AST_OFF_TXSTA, 33'h26);
        rd(`AST_OFF_FLAGS, 33'h02);
        $display("back to back done");
        wr(`AST_OFF_TXSTA, 8'h34);
        wr(`AST_OFF_TXBUF, b);
        repeat (40) @(posedge clk_i);
        rd(`AST_OFF_TXSTA, 33'h36);
        tx_q.push_back({2'b10, b});
        wr(`AST_OFF_TXSTA, 8'h24);
        wait_tx;
        $display("sync select done");
        nine = 1'b1;
        wr(`AST_OFF_TXSTA, 8'h65);
        wr(`AST_OFF_RCSTA, 8'hd0);
        tx_q.push_back({2'b11, b});
        fork
            snd({1'b1, ~b}, 1'b1);
            wr(`AST_OFF_TXBUF, b);
        join
        wait_rx;
        rd(`AST_OFF_RCSTA, 33'hd1);
        rd(`AST_OFF_RXBUF, {25'h0, ~b});
        wait_tx;
        wr(`AST_OFF_RCSTA, 8'hd8);
        snd({1'b0, b}, 1'b1);
        check({32'h0, rx_req}, 33'h0);
        snd({1'b1, ~b}, 1'b1);
        wait_rx;
        rd(`AST_OFF_RXBUF, {25'h0, ~b});
        $display("nine bit done");
        nine = 1'b0;
        wr(`AST_OFF_RCSTA, 8'h90);
        snd({1'b0, b}, 1'b0);
        wait_rx;
        rd(`AST_OFF_RCSTA, 33'h94);
        rd(`AST_OFF_RXBUF, {25'h0, b});
        wr(`AST_OFF_RCSTA, 8'h80);
        rd(`AST_OFF_RCSTA, 33'h80);
        wr(`AST_OFF_RCSTA, 8'h90);
        snd({1'b0, b}, 1'b1);
        snd({1'b0, ~b}, 1'b1);
        rd(`AST_OFF_RCSTA, 33'h92);
        rd(`AST_OFF_RXBUF, {25'h0, b});
        wr(`AST_OFF_RCSTA, 8'h80);
        rd(`AST_OFF_RCSTA, 33'h80);
        $display("errors done");
        wr(`AST_OFF_RCSTA, 8'h90);
        wr(`AST_OFF_BAUD, 8'h02);
        fork
            ast_remote_node_inst.hold_low(300);
            begin
                repeat (20) @(posedge clk_i);
                rd(`AST_OFF_FLAGS, 33'h03);
                rd(`AST_OFF_BAUD, 33'h02);
            end
        join
        repeat (5) @(posedge clk_i);
        rd(`AST_OFF_BAUD, 33'h00);
        rd(`AST_OFF_RCSTA, 33'h90);
        apb(1'b0, `AST_OFF_RXBUF, 32'h0);
        rd(`AST_OFF_FLAGS, 33'h02);
        snd({1'b0, b}, 1'b1);
        wait_rx;
        rd(`AST_OFF_RXBUF, {25'h0, b});
        $display("wake up done");
        give_verdict;
    end

    initial
    begin
        repeat (40000) @(posedge clk_i);
        bad_count++;
        give_verdict;
    end
endmodule : test_async_serial_transceiver

// ---- verilog/ast_top.sv ----
// Contract
// - transceiver runs asynchronously while synchronous select is clear
// - each character: one start bit, eight or nine data bits, one stop
// - data bits go out and come in least significant bit first
// - transmitter and receiver independent, sharing format and baud rate
// - baud generator gives 16x or 64x bit rate per speed selects
// - no hardware parity; software may use the ninth bit
// - shifter loads from buffer only after stop bit and if buffer full
// - load takes one cycle, empties buffer and sets buffer-empty flag
// - buffer-empty flag sets regardless of enable, software cannot clear it
// - after a buffer write the flag clears in the second cycle, unless a load in the cycle after the write keeps it set
// - read-only shift-register-empty bit shows shifter empty, no interrupt
// - setting transmit enable also sets the buffer-empty flag
// - nine-bit transmit sends the transmit ninth bit field
// - receiver samples the line at 16 times the baud rate
// - received character sets receive-complete flag, request if enabled
// - nine-bit receive puts ninth bit in receive status register
// - framing and overrun reported; clearing receive enable clears them
// - address detect passes only address characters to the buffer in nine-bit receive; with nine-bit clear it passes all
// - wake-up enable stops normal reception, receiver watches the line
// - falling line edge while armed sets receive-complete flag
// - wake flag set in clock domain; reading receive buffer clears it
// - hardware clears wake-up enable when line rises after the event
`include "ast_consts.svh"
module ast_top #(
    parameter int DIV_W = 16,
    parameter int OVS = 16
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic receive_line_i,
    output logic transmit_line_o,
    output logic tx_request_o,
    output logic rx_request_o
);
    if (DIV_W != 16 || OVS != 16)
    begin : g_chk
        $error("ast_top serves a 16-bit divider and 16x sampling only");
    end

    logic serial_port_enable_q, rx9_q, continuous_receive_enable_q, address_detect_enable_q, framing_error_q, overrun_error_q, received_ninth_bit_q;
    logic tx9_q, transmit_enable_q, sync_q, high_speed_select_q, transmit_ninth_bit_q, wide_generator_select_q, wue_q;
    logic txie_q, rcie_q, txif_q, rcif_q, full_q, wr_d1_q;
    logic [7:0] divh_q, divl_q, txbuf_q, rcreg_q;
    logic [DIV_W-1:0] brg_q;
    logic [1:0] pre_q;
    logic [3:0] tph_q, tbit_q, rph_q, rbit_q;
    logic [8:0] tsr_q, rsr_q;
    logic rx_q, rx_p_q;
    ast_pkg::ast_tx_state_t tx_st_q;
    ast_pkg::ast_rx_state_t rx_st_q;

    // apb decode: pready answers in the first access cycle
    wire acc = psel_i & penable_i & pready_o;
    wire wr = acc & pwrite_i;
    wire rd = acc & ~pwrite_i;
    wire s_rcsta = paddr_i == `AST_OFF_RCSTA;
    wire s_txbuf = paddr_i == `AST_OFF_TXBUF;
    wire s_txsta = paddr_i == `AST_OFF_TXSTA;
    wire s_baud = paddr_i == `AST_OFF_BAUD;
    wire s_divh = paddr_i == `AST_OFF_DIVH;
    wire s_divl = paddr_i == `AST_OFF_DIVL;
    wire s_rxbuf = paddr_i == `AST_OFF_RXBUF;
    wire s_inten = paddr_i == `AST_OFF_INTEN;
    wire s_flags = paddr_i == `AST_OFF_FLAGS;
    wire mapped = s_rcsta | s_txbuf | s_txsta | s_baud | s_divh
        | s_divl | s_rxbuf | s_inten | s_flags;
    wire [7:0] wd = pwdata_i[7:0];
    wire w_rcsta = wr & s_rcsta;
    wire w_txbuf = wr & s_txbuf;
    wire w_txsta = wr & s_txsta;
    wire w_baud = wr & s_baud;
    wire rd_rxbuf = rd & s_rxbuf;

    wire active = serial_port_enable_q & ~sync_q;
    wire shift_register_empty = tx_st_q == ast_pkg::TX_IDLE;
    wire [7:0] rcsta_v = {serial_port_enable_q, rx9_q, 1'b0, continuous_receive_enable_q, address_detect_enable_q,
        framing_error_q, overrun_error_q, received_ninth_bit_q};
    wire [7:0] txsta_v = {1'b0, tx9_q, transmit_enable_q, sync_q, 1'b0, high_speed_select_q,
        shift_register_empty, transmit_ninth_bit_q};
    wire [7:0] baud_v = {4'h0, wide_generator_select_q, 1'b0, wue_q, 1'b0};
    wire [7:0] rd_v = s_rcsta ? rcsta_v : s_txbuf ? txbuf_q
        : s_txsta ? txsta_v : s_baud ? baud_v : s_divh ? divh_q
        : s_divl ? divl_q : s_rxbuf ? rcreg_q
        : s_inten ? {6'h00, txie_q, rcie_q}
        : s_flags ? {6'h00, txif_q, rcif_q} : 8'h00;

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
        else
        begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~mapped;
            prdata_o <= {24'h00_0000, rd_v};
        end
    end

    // plain control registers
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            {serial_port_enable_q, rx9_q, continuous_receive_enable_q, address_detect_enable_q} <= 4'h0;
            {tx9_q, transmit_enable_q, sync_q, high_speed_select_q, transmit_ninth_bit_q} <= 5'h00;
            {wide_generator_select_q, txie_q, rcie_q} <= 3'h0;
            divh_q <= 8'h00;
            divl_q <= 8'h00;
        end
        else
        begin
            if (w_rcsta)
            begin
                serial_port_enable_q <= wd[`AST_RC_SERIAL_PORT_ENABLE];
                rx9_q <= wd[`AST_RC_RX9];
                continuous_receive_enable_q <= wd[`AST_RC_CONTINUOUS_RECEIVE_ENABLE];
                address_detect_enable_q <= wd[`AST_RC_ADDRESS_DETECT_ENABLE];
            end
            if (w_txsta)
            begin
                tx9_q <= wd[`AST_TX_TX9];
                transmit_enable_q <= wd[`AST_TX_TRANSMIT_ENABLE];
                sync_q <= wd[`AST_TX_SYNC];
                high_speed_select_q <= wd[`AST_TX_HIGH_SPEED_SELECT];
                transmit_ninth_bit_q <= wd[`AST_TX_TRANSMIT_NINTH_BIT];
            end
            if (w_baud)
                wide_generator_select_q <= wd[`AST_BD_WIDE_GENERATOR_SELECT];
            if (wr & s_inten)
            begin
                txie_q <= wd[`AST_EN_TXIE];
                rcie_q <= wd[`AST_EN_RCIE];
            end
            if (wr & s_divh)
                divh_q <= wd;
            if (wr & s_divl)
                divl_q <= wd;
        end
    end

    // baud generator; x64 is made by a /4 prescale on the x16 path
    wire [DIV_W-1:0] div = wide_generator_select_q ? {divh_q, divl_q} : {8'h00, divl_q};
    wire base = brg_q == '0;
    wire fast = high_speed_select_q | wide_generator_select_q;
    wire tick = base & (fast | pre_q == 2'h3);

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            brg_q <= '0;
            pre_q <= 2'h0;
        end
        else if (!serial_port_enable_q)
        begin
            brg_q <= '0;
            pre_q <= 2'h0;
        end
        else
        begin
            brg_q <= base ? div : brg_q - 1'b1;
            if (base)
                pre_q <= pre_q + 2'h1;
        end
    end

    // transmitter
    wire tx_run = transmit_enable_q & active;
    wire load = shift_register_empty & full_q & tx_run;
    wire transmit_enable_rise = w_txsta & wd[`AST_TX_TRANSMIT_ENABLE] & ~transmit_enable_q;
    wire t_last = tph_q == `AST_PH_LAST;
    wire [3:0] tnb = tx9_q ? 4'h9 : 4'h8;

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            full_q <= 1'b0;
            txbuf_q <= 8'h00;
            wr_d1_q <= 1'b0;
            txif_q <= 1'b0;
        end
        else
        begin
            wr_d1_q <= w_txbuf;
            if (w_txbuf)
                txbuf_q <= wd;
            if (w_txbuf)
                full_q <= 1'b1;
            else if (load)
                full_q <= 1'b0;
            // set beats the delayed clear; software has no clear path
            if (load | transmit_enable_rise)
                txif_q <= 1'b1;
            else if (wr_d1_q)
                txif_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            tx_st_q <= ast_pkg::TX_IDLE;
            tsr_q <= 9'h000;
            tph_q <= 4'h0;
            tbit_q <= 4'h0;
        end
        else if (!tx_run)
            tx_st_q <= ast_pkg::TX_IDLE;
        else
        begin
            case (tx_st_q)
                ast_pkg::TX_IDLE:
                    if (load)
                    begin
                        tsr_q <= {tx9_q & transmit_ninth_bit_q, txbuf_q};
                        tph_q <= 4'h0;
                        tbit_q <= 4'h0;
                        tx_st_q <= ast_pkg::TX_START;
                    end
                ast_pkg::TX_START:
                    if (tick)
                    begin
                        tph_q <= tph_q + 4'h1;
                        if (t_last)
                            tx_st_q <= ast_pkg::TX_DATA;
                    end
                ast_pkg::TX_DATA:
                    if (tick)
                    begin
                        tph_q <= tph_q + 4'h1;
                        if (t_last)
                        begin
                            tsr_q <= {1'b0, tsr_q[8:1]};
                            tbit_q <= tbit_q + 4'h1;
                            if (tbit_q == tnb - 4'h1)
                                tx_st_q <= ast_pkg::TX_STOP;
                        end
                    end
                ast_pkg::TX_STOP:
                    if (tick)
                    begin
                        tph_q <= tph_q + 4'h1;
                        if (t_last)
                            tx_st_q <= ast_pkg::TX_IDLE;
                    end
                default:
                    tx_st_q <= ast_pkg::TX_IDLE;
            endcase
        end
    end

    wire tx_bit = tx_st_q == ast_pkg::TX_START ? 1'b0
        : tx_st_q == ast_pkg::TX_DATA ? tsr_q[0] : 1'b1;

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            transmit_line_o <= 1'b1;
            tx_request_o <= 1'b0;
            rx_request_o <= 1'b0;
        end
        else
        begin
            transmit_line_o <= tx_bit;
            tx_request_o <= txif_q & txie_q;
            rx_request_o <= rcif_q & rcie_q;
        end
    end

    // receiver: line is registered once, edges from two samples
    wire fall = rx_p_q & ~rx_q;
    wire rise = ~rx_p_q & rx_q;
    wire r_last = rph_q == `AST_PH_LAST;
    wire [3:0] rnb = rx9_q ? 4'h9 : 4'h8;
    wire rx_run = continuous_receive_enable_q & active & ~wue_q;
    wire rx_done = rx_st_q == ast_pkg::RX_STOP & tick & r_last;
    wire ninth = rx9_q & rsr_q[8];
    wire [7:0] rbyte = rx9_q ? rsr_q[7:0] : rsr_q[8:1];
    wire accept = ~(address_detect_enable_q & rx9_q & ~rsr_q[8]);
    wire ovr = rcif_q & ~rd_rxbuf;
    wire wake = rx_st_q == ast_pkg::RX_IDLE & wue_q & active & fall;
    wire store = rx_done & accept & ~ovr;
    wire rc_set = store | wake;

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            rx_q <= 1'b1;
            rx_p_q <= 1'b1;
            rx_st_q <= ast_pkg::RX_IDLE;
            rsr_q <= 9'h000;
            rph_q <= 4'h0;
            rbit_q <= 4'h0;
        end
        else
        begin
            rx_q <= receive_line_i;
            rx_p_q <= rx_q;
            case (rx_st_q)
                ast_pkg::RX_IDLE:
                    if (wake)
                        rx_st_q <= ast_pkg::RX_WLOW;
                    else if (rx_run & ~overrun_error_q & fall)
                    begin
                        rph_q <= 4'h0;
                        rbit_q <= 4'h0;
                        rx_st_q <= ast_pkg::RX_START;
                    end
                ast_pkg::RX_START:
                    if (!rx_run)
                        rx_st_q <= ast_pkg::RX_IDLE;
                    else if (tick)
                    begin
                        rph_q <= rph_q + 4'h1;
                        // a glitch shorter than half a bit is no start
                        if (rph_q == `AST_PH_MID)
                        begin
                            rph_q <= 4'h0;
                            rx_st_q <= rx_q ? ast_pkg::RX_IDLE
                                : ast_pkg::RX_DATA;
                        end
                    end
                ast_pkg::RX_DATA:
                    if (!rx_run)
                        rx_st_q <= ast_pkg::RX_IDLE;
                    else if (tick)
                    begin
                        rph_q <= rph_q + 4'h1;
                        if (r_last)
                        begin
                            rsr_q <= {rx_q, rsr_q[8:1]};
                            rbit_q <= rbit_q + 4'h1;
                            if (rbit_q == rnb - 4'h1)
                                rx_st_q <= ast_pkg::RX_STOP;
                        end
                    end
                ast_pkg::RX_STOP:
                    if (!rx_run)
                        rx_st_q <= ast_pkg::RX_IDLE;
                    else if (tick)
                    begin
                        rph_q <= rph_q + 4'h1;
                        if (r_last)
                            rx_st_q <= ast_pkg::RX_IDLE;
                    end
                ast_pkg::RX_WLOW:
                    if (rise | ~wue_q)
                        rx_st_q <= ast_pkg::RX_IDLE;
                default:
                    rx_st_q <= ast_pkg::RX_IDLE;
            endcase
        end
    end

    // receive buffer, flags and errors; every hardware set wins its clear
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            rcreg_q <= 8'h00;
            {rcif_q, received_ninth_bit_q, framing_error_q, overrun_error_q, wue_q} <= 5'h00;
        end
        else
        begin
            if (store)
            begin
                rcreg_q <= rbyte;
                received_ninth_bit_q <= ninth;
                framing_error_q <= ~rx_q;
            end
            else if (w_rcsta & ~wd[`AST_RC_CONTINUOUS_RECEIVE_ENABLE])
                framing_error_q <= 1'b0;
            if (rx_done & accept & ovr)
                overrun_error_q <= 1'b1;
            else if (w_rcsta & ~wd[`AST_RC_CONTINUOUS_RECEIVE_ENABLE])
                overrun_error_q <= 1'b0;
            if (rc_set)
                rcif_q <= 1'b1;
            else if (rd_rxbuf)
                rcif_q <= 1'b0;
            // a software write in the same cycle outranks the auto clear
            if (w_baud)
                wue_q <= wd[`AST_BD_WUE];
            else if (rx_st_q == ast_pkg::RX_WLOW & rise)
                wue_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    property p_async_only;
        !active |=> tx_st_q == ast_pkg::TX_IDLE;
    endproperty
    a_async_only: assert property (p_async_only)
        else $error("transmitter busy outside asynchronous mode");

    property p_start_low;
        tx_st_q == ast_pkg::TX_START && tx_run |=> !transmit_line_o;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("start bit not low");

    property p_load;
        load |=> txif_q && !full_q && tx_st_q == ast_pkg::TX_START
            && transmit_line_o ##1 !transmit_line_o;
    endproperty
    a_load: assert property (p_load)
        else $error("load did not empty buffer and start");

    // start or data state cannot reach a load within the next two cycles
    property p_flag_late;
        w_txbuf && !transmit_enable_rise && (tx_st_q == ast_pkg::TX_START
            || tx_st_q == ast_pkg::TX_DATA)
            |=> $stable(txif_q) ##1 !txif_q;
    endproperty
    a_flag_late: assert property (p_flag_late)
        else $error("buffer-empty flag cleared at wrong cycle");

    property p_transmit_enable_flag;
        transmit_enable_rise |=> txif_q && transmit_enable_q;
    endproperty
    a_transmit_enable_flag: assert property (p_transmit_enable_flag)
        else $error("transmit enable did not set flag");

    property p_wake;
        wake |=> rcif_q && rx_st_q == ast_pkg::RX_WLOW;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake edge did not set receive flag");

    property p_wue_clr;
        rx_st_q == ast_pkg::RX_WLOW && rise && !w_baud
            |=> !wue_q && rx_st_q == ast_pkg::RX_IDLE;
    endproperty
    a_wue_clr: assert property (p_wue_clr)
        else $error("wake-up enable not cleared on rise");

    property p_rd_clr;
        rd_rxbuf && !rc_set |=> !rcif_q;
    endproperty
    a_rd_clr: assert property (p_rd_clr)
        else $error("receive buffer read left flag set");

    property p_addr;
        rx_done && address_detect_enable_q && rx9_q && !rsr_q[8]
            |=> $stable(rcreg_q) && $stable(received_ninth_bit_q);
    endproperty
    a_addr: assert property (p_addr)
        else $error("data character passed address filter");

    property p_framing_error;
        store && !rx_q |=> framing_error_q && rcif_q;
    endproperty
    a_framing_error: assert property (p_framing_error)
        else $error("low stop bit not flagged");

    c_load: cover property (load ##1 tx_st_q == ast_pkg::TX_START);
    c_rx: cover property (store);
    c_ovr: cover property (rx_done && accept && ovr);
    c_wake: cover property (wake ##[1:400] !wue_q);
endmodule : ast_top
